//--- logic/reload_capture_timer_consts.vh
// register map, field positions and counts for the reload/capture timer
// assumes byte-wide registers on a plain strobe port, one system clock
// How it works
// - both mode bits clear: one 16-bit counter
// - 16-bit wrap reloads pair, sets high flag
// - 16-bit irq on overflow, low wrap optional
// - clock: system, system/12, external/8 synchronised
// - split: two independent 8-bit reload timers
// - run gates all, split gates high only
// - per-byte select system clock else ext select
// - each byte wrap sets its overflow flag
// - split irq on high, either with low enable
// - flags cleared only by software writing zero
// - low flag sets on low wrap always
// - irq from high flag or enabled low flag
// - capture mode, source sof or oscillator fall
// - capture 16-bit: latch whole count, irq
// - capture split: latch both bytes, irq
// - reload bytes at 0xCA, 0xCB, reset zero
// - count bytes at 0xCC, 0xCD, live
// - clock selects bits 5 and 4, shared reg
`ifndef RELOAD_CAPTURE_TIMER_CONSTS_VH
`define RELOAD_CAPTURE_TIMER_CONSTS_VH

// register addresses
`define ADDR_CONTROL      8'hC8
`define ADDR_RELOAD_LOW   8'hCA
`define ADDR_RELOAD_HIGH  8'hCB
`define ADDR_COUNT_LOW    8'hCC
`define ADDR_COUNT_HIGH   8'hCD
`define ADDR_CLOCK_CTRL   8'h8E

// control register fields
`define BIT_HIGH_FLAG     7
`define BIT_LOW_FLAG      6
`define BIT_LOW_IRQ_EN    5
`define BIT_CAPTURE_EN    4
`define BIT_SPLIT_EN      3
`define BIT_RUN           2
`define BIT_CAP_SRC       1
`define BIT_EXT_CLK       0

// clock control fields
`define BIT_HIGH_CLK_SEL  5
`define BIT_LOW_CLK_SEL   4

// reset values and constants
`define RESET_BYTE        8'h00
`define BYTE_ALL_ONES     8'hFF
`define SYS_DIV           12
`define EXT_DIV           8

`endif

//--- logic/tick_divider.v
// divides a stream of input ticks by a fixed ratio into single-cycle ticks
// assumes tick_in is already synchronous to clk_sys
`timescale 1ns/100ps
module tick_divider #(
  parameter DIVIDE = 12,           // ticks in per tick out
  parameter WIDTH  = 4             // counter width, holds DIVIDE-1
) (
  // clock and reset
  input  wire clk_sys,
  input  wire sys_rst,
  // tick stream
  input  wire tick_in,
  output reg  tick_out
);
  localparam [31:0]      LAST_FULL = DIVIDE - 1;                     // terminal count, full width
  localparam [WIDTH-1:0] LAST      = LAST_FULL[WIDTH-1:0];           // cut to counter width
  localparam [WIDTH-1:0] ZERO      = {WIDTH{1'b0}};                  // restart value
  localparam [WIDTH-1:0] ONE       = {{(WIDTH-1){1'b0}}, 1'b1};      // step

  reg [WIDTH-1:0] count_reg;                  // ticks seen in this period

  // count input ticks, pulse on the last one
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= ZERO;
      tick_out  <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (count_reg == LAST) begin
          count_reg <= ZERO;
          tick_out  <= 1'b1;
        end else begin
          count_reg <= count_reg + ONE;
        end
      end
    end
  end
endmodule

//--- logic/reload_capture_timer.v
// timer with auto-reload, split 8-bit mode and capture, byte registers
// assumes a plain strobe register port on clk_sys; ext_osc, sof_event and
// low_freq_osc are raw levels from other domains, synchronised here
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`include "reload_capture_timer_consts.vh"
module reload_capture_timer (
  // clock and reset
  input  wire       clk_sys,
  input  wire       sys_rst,
  // register port
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_write,
  input  wire       reg_read,
  output reg  [7:0] reg_rdata,
  // event sources
  input  wire       ext_osc,
  input  wire       sof_event,
  input  wire       low_freq_osc,
  // processor interrupt side
  input  wire       timer_irq_enable,
  output wire       timer_irq
);
  // control state
  reg        high_overflow_flag_reg;   // high byte wrap seen
  reg        low_overflow_flag_reg;    // low byte wrap seen
  reg        low_irq_enable_reg;       // low wrap may interrupt
  reg        capture_enable_reg;       // capture mode
  reg        split_enable_reg;         // two 8-bit timers
  reg        run_control_reg;          // run gate
  reg        capture_source_reg;       // 0 sof, 1 oscillator fall
  reg        ext_clock_select_reg;     // 0 sys/12, 1 ext/8
  reg        high_clock_select_reg;    // high byte on system clock
  reg        low_clock_select_reg;     // low byte on system clock
  reg  [7:0] reload_low_reg;           // reload / captured low
  reg  [7:0] reload_high_reg;          // reload / captured high
  reg  [7:0] count_low_reg;            // live low byte
  reg  [7:0] count_high_reg;           // live high byte

  // synchronisers: first stage read only by the second
  reg  [1:0] ext_sync_reg;
  reg  [1:0] sof_sync_reg;
  reg  [1:0] lfo_sync_reg;
  reg        ext_prev_reg;             // edge history, second stage only
  reg        sof_prev_reg;
  reg        lfo_prev_reg;

  wire       ext_rise_tick;            // one external oscillator period
  wire       sys_div_tick;             // system clock / 12
  wire       ext_div_tick;             // external clock / 8
  wire       divided_tick;             // chosen divided source
  wire       low_tick;                 // low byte advances
  wire       high_tick;                // high byte (split) advances
  wire       capture_pulse;            // one cycle per capture event
  wire       low_wrap;                 // low byte steps on from 0xFF
  wire       high_wrap;                // high byte steps on from 0xFF
  wire       run16;                    // 16-bit count enable
  wire       write_control;
  wire       write_clock_ctrl;

  // read back a control byte from the live bits
  function [7:0] pack_control;
    input dummy;
    begin
      pack_control = `RESET_BYTE;
      pack_control[`BIT_HIGH_FLAG]  = high_overflow_flag_reg;
      pack_control[`BIT_LOW_FLAG]   = low_overflow_flag_reg;
      pack_control[`BIT_LOW_IRQ_EN] = low_irq_enable_reg;
      pack_control[`BIT_CAPTURE_EN] = capture_enable_reg;
      pack_control[`BIT_SPLIT_EN]   = split_enable_reg;
      pack_control[`BIT_RUN]        = run_control_reg;
      pack_control[`BIT_CAP_SRC]    = capture_source_reg;
      pack_control[`BIT_EXT_CLK]    = ext_clock_select_reg;
    end
  endfunction

  // synchronise the foreign levels, keep one stage of history
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ext_sync_reg <= 2'h0;
      sof_sync_reg <= 2'h0;
      lfo_sync_reg <= 2'h0;
      ext_prev_reg <= 1'b0;
      sof_prev_reg <= 1'b0;
      lfo_prev_reg <= 1'b0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[0], ext_osc};
      sof_sync_reg <= {sof_sync_reg[0], sof_event};
      lfo_sync_reg <= {lfo_sync_reg[0], low_freq_osc};
      ext_prev_reg <= ext_sync_reg[1];
      sof_prev_reg <= sof_sync_reg[1];
      lfo_prev_reg <= lfo_sync_reg[1];
    end
  end

  // external oscillator must be well below clk_sys/2 to be seen
  assign ext_rise_tick = ext_sync_reg[1] & ~ext_prev_reg;

  // sys/12 from a constant tick, ext/8 from external rises
  tick_divider #(.DIVIDE(`SYS_DIV), .WIDTH(4)) sys_div (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .tick_in  (1'b1),
    .tick_out (sys_div_tick)
  );
  tick_divider #(.DIVIDE(`EXT_DIV), .WIDTH(4)) ext_div (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .tick_in  (ext_rise_tick),
    .tick_out (ext_div_tick)
  );

  // shared divided source, then per-byte system clock override
  assign divided_tick = ext_clock_select_reg ? ext_div_tick : sys_div_tick;
  assign low_tick     = low_clock_select_reg  | divided_tick;
  assign high_tick    = high_clock_select_reg | divided_tick;

  // capture events: sof rising edge or oscillator falling edge
  assign capture_pulse = capture_enable_reg &
    (capture_source_reg ? (lfo_prev_reg & ~lfo_sync_reg[1])
                        : (sof_sync_reg[1] & ~sof_prev_reg));

  // 16-bit modes use the low byte select; split low byte ignores run
  assign run16     = ~split_enable_reg & run_control_reg & low_tick;
  assign low_wrap  = (count_low_reg == `BYTE_ALL_ONES) &
                     (split_enable_reg ? low_tick : run16);
  assign high_wrap = split_enable_reg ?
                     ((count_high_reg == `BYTE_ALL_ONES) & run_control_reg & high_tick) :
                     (low_wrap & (count_high_reg == `BYTE_ALL_ONES));

  assign write_control    = reg_write & (reg_addr == `ADDR_CONTROL);
  assign write_clock_ctrl = reg_write & (reg_addr == `ADDR_CLOCK_CTRL);

  // control and clock-select registers; hardware sets beat software clears
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      high_overflow_flag_reg <= 1'b0;
      low_overflow_flag_reg  <= 1'b0;
      low_irq_enable_reg     <= 1'b0;
      capture_enable_reg     <= 1'b0;
      split_enable_reg       <= 1'b0;
      run_control_reg        <= 1'b0;
      capture_source_reg     <= 1'b0;
      ext_clock_select_reg   <= 1'b0;
      high_clock_select_reg  <= 1'b0;
      low_clock_select_reg   <= 1'b0;
    end else begin
      if (write_control) begin
        // flags take what software writes, only a wrap sets them otherwise
        high_overflow_flag_reg <= reg_wdata[`BIT_HIGH_FLAG] | high_wrap;
        low_overflow_flag_reg  <= reg_wdata[`BIT_LOW_FLAG] | low_wrap;
        low_irq_enable_reg     <= reg_wdata[`BIT_LOW_IRQ_EN];
        capture_enable_reg     <= reg_wdata[`BIT_CAPTURE_EN];
        split_enable_reg       <= reg_wdata[`BIT_SPLIT_EN];
        run_control_reg        <= reg_wdata[`BIT_RUN];
        capture_source_reg     <= reg_wdata[`BIT_CAP_SRC];
        ext_clock_select_reg   <= reg_wdata[`BIT_EXT_CLK];
      end else begin
        // sticky: no hardware clear, not even on interrupt entry
        if (high_wrap)
          high_overflow_flag_reg <= 1'b1;
        if (low_wrap)
          low_overflow_flag_reg <= 1'b1;
      end
      if (write_clock_ctrl) begin
        high_clock_select_reg <= reg_wdata[`BIT_HIGH_CLK_SEL];
        low_clock_select_reg  <= reg_wdata[`BIT_LOW_CLK_SEL];
      end
    end
  end

  // counter bytes; counting wins over a same-cycle software write
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      count_low_reg  <= `RESET_BYTE;
      count_high_reg <= `RESET_BYTE;
    end else if (split_enable_reg) begin
      // two independent bytes
      if (split_enable_reg & low_tick) begin
        if (low_wrap & ~capture_enable_reg)
          count_low_reg <= reload_low_reg;
        else
          count_low_reg <= count_low_reg + 8'h01;
      end else if (reg_write && reg_addr == `ADDR_COUNT_LOW) begin
        count_low_reg <= reg_wdata;
      end
      if (run_control_reg & high_tick) begin
        if (high_wrap & ~capture_enable_reg)
          count_high_reg <= reload_high_reg;
        else
          count_high_reg <= count_high_reg + 8'h01;
      end else if (reg_write && reg_addr == `ADDR_COUNT_HIGH) begin
        count_high_reg <= reg_wdata;
      end
    end else if (run16) begin
      // one 16-bit counter
      if (high_wrap & ~capture_enable_reg) begin
        count_low_reg  <= reload_low_reg;
        count_high_reg <= reload_high_reg;
      end else begin
        {count_high_reg, count_low_reg} <=
          {count_high_reg, count_low_reg} + 16'h0001;
      end
    end else begin
      if (reg_write && reg_addr == `ADDR_COUNT_LOW)
        count_low_reg <= reg_wdata;
      if (reg_write && reg_addr == `ADDR_COUNT_HIGH)
        count_high_reg <= reg_wdata;
    end
  end

  // reload bytes: software value, or captured count in capture mode
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reload_low_reg  <= `RESET_BYTE;
      reload_high_reg <= `RESET_BYTE;
    end else if (capture_pulse) begin
      reload_low_reg  <= count_low_reg;
      reload_high_reg <= count_high_reg;
    end else if (reg_write) begin
      if (reg_addr == `ADDR_RELOAD_LOW)
        reload_low_reg <= reg_wdata;
      if (reg_addr == `ADDR_RELOAD_HIGH)
        reload_high_reg <= reg_wdata;
    end
  end

  // capture pulses are remembered until the next control write
  reg capture_seen_reg;   // capture event pending as interrupt
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst)
      capture_seen_reg <= 1'b0;
    else if (capture_pulse)
      capture_seen_reg <= 1'b1;
    else if (write_control)
      capture_seen_reg <= 1'b0;
  end

  // level request while any enabled cause is set
  assign timer_irq = timer_irq_enable &
    (high_overflow_flag_reg | (low_overflow_flag_reg & low_irq_enable_reg) |
     capture_seen_reg);

  // read data one cycle after the strobe, zero otherwise
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= `RESET_BYTE;
    end else if (reg_read) begin
      case (reg_addr)
        `ADDR_CONTROL:     reg_rdata <= pack_control(1'b0);
        `ADDR_RELOAD_LOW:  reg_rdata <= reload_low_reg;
        `ADDR_RELOAD_HIGH: reg_rdata <= reload_high_reg;
        `ADDR_COUNT_LOW:   reg_rdata <= count_low_reg;
        `ADDR_COUNT_HIGH:  reg_rdata <= count_high_reg;
        `ADDR_CLOCK_CTRL:  reg_rdata <= {2'h0, high_clock_select_reg,
                                         low_clock_select_reg, 4'h0};
        default:           reg_rdata <= `RESET_BYTE;          // unmapped
      endcase
    end else begin
      reg_rdata <= `RESET_BYTE;
    end
  end
endmodule

//--- testbench/timer_port_monitor.sv
// port checker: register read timing, stored fields, sticky flags, irq
// assumes one clock domain and the strobe port of reload_capture_timer
`timescale 1ns/100ps
`include "reload_capture_timer_consts.vh"
module timer_port_monitor (
  // clock and reset
  input wire       clk_sys,
  input wire       sys_rst,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_write,
  input wire       reg_read,
  input wire [7:0] reg_rdata,
  // interrupt side
  input wire       timer_irq_enable,
  input wire       timer_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // strobe decodes, nets so the properties stay short
  wire rd_ctl = reg_read && reg_addr == `ADDR_CONTROL;
  wire wr_ctl = reg_write && reg_addr == `ADDR_CONTROL;
  wire mapped = rd_ctl || reg_addr == `ADDR_RELOAD_LOW || reg_addr == `ADDR_RELOAD_HIGH ||
                reg_addr == `ADDR_COUNT_LOW || reg_addr == `ADDR_COUNT_HIGH ||
                reg_addr == `ADDR_CLOCK_CTRL;
  property p_rdata_idle;
    !reg_read |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_unmapped;
    reg_read && !mapped |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // a pending request only drops through a control write or the enable
  property p_irq_hold;
    (timer_irq && !wr_ctl) ##1 timer_irq_enable |-> timer_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped by hardware");
  property p_flag_irq;
    rd_ctl ##1 (reg_rdata[7] && timer_irq_enable) |-> timer_irq;
  endproperty
  a_flag_irq: assert property (p_flag_irq) else $error("high flag without irq");
  // no write between two control reads, so the high flag may not vanish
  property p_flag_sticky;
    rd_ctl ##1 (reg_rdata[7] && !reg_write) ##1 rd_ctl |=> reg_rdata[7];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by hardware");
  property p_reload_rw;
    reg_write && reg_addr == `ADDR_RELOAD_LOW ##1 reg_read && reg_addr == `ADDR_RELOAD_LOW
      |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_reload_rw: assert property (p_reload_rw) else $error("reload low not stored");
  property p_ctl_rw;
    wr_ctl ##1 rd_ctl |=> reg_rdata[5:0] == $past(reg_wdata[5:0], 2);
  endproperty
  a_ctl_rw: assert property (p_ctl_rw) else $error("control bits not stored");
  property p_clk_rw;
    reg_write && reg_addr == `ADDR_CLOCK_CTRL ##1 reg_read && reg_addr == `ADDR_CLOCK_CTRL
      |=> reg_rdata[5:4] == $past(reg_wdata[5:4], 2);
  endproperty
  a_clk_rw: assert property (p_clk_rw) else $error("clock selects not stored");
endmodule
bind reload_capture_timer timer_port_monitor u_mon (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .timer_irq_enable(timer_irq_enable), .timer_irq(timer_irq));

//--- testbench/testbench.sv
// self-checking bench: register tasks, counting model, capture events
// assumes the header constants; the port checker is bound separately
`timescale 1ns/100ps
`include "reload_capture_timer_consts.vh"
// compare a seen value with the model and count it
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  $display("BAD %s exp %h got %h", n, e, g); num_errors++; end end
module testbench;
  // clock, reset and design inputs
  reg         clk_sys          = 1'b0;
  reg         sys_rst          = 1'b1;
  reg  [7:0]  reg_addr         = 8'h00;
  reg  [7:0]  reg_wdata        = 8'h00;
  reg         reg_write        = 1'b0;
  reg         reg_read         = 1'b0;
  reg         ext_osc          = 1'b0;
  reg         sof_event        = 1'b0;
  reg         low_freq_osc     = 1'b1;
  reg         timer_irq_enable = 1'b0;
  wire [7:0]  reg_rdata;
  wire        timer_irq;
  // bench state
  int         num_errors       = 0;
  int         compares         = 0;
  reg  [7:0]  v;
  reg  [16:0] m;
  reg  [15:0] r;
  reg  [15:0] rnd;
  reload_capture_timer dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .ext_osc(ext_osc), .sof_event(sof_event), .low_freq_osc(low_freq_osc),
    .timer_irq_enable(timer_irq_enable), .timer_irq(timer_irq));
  always #20 clk_sys = ~clk_sys;
  // one write; strobe dropped after its edge, so calls leave a gap
  task automatic wr(input [7:0] a, input [7:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  // read; data taken in the following cycle only
  task automatic rd(input [7:0] a, output [7:0] d);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // write directly followed by a read of the same place
  task automatic wr_rd(input [7:0] a, input [7:0] d, output [7:0] q);
    wr(a, d);
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task automatic chk(input [7:0] a, input [7:0] e, input string n);
    rd(a, v);
    `CHK(n, e, v)
  endtask
  // selected bytes get the system clock for exactly 2+j edges; they count only where run allows
  task automatic burst(input [7:0] sel, input int j);
    wr(`ADDR_CLOCK_CTRL, sel);
    repeat (j) @(posedge clk_sys);
    wr(`ADDR_CLOCK_CTRL, 8'h00);
  endtask
  // counting model: n ticks, reload from rl when leaving top
  function automatic [16:0] adv(input [15:0] c, rl, top, input int n);
    adv = {1'b0, c};
    repeat (n) adv = (adv[15:0] == top) ? {1'b1, rl} : {adv[16], adv[15:0] + 16'h0001};
  endfunction
  task tally_and_finish;
    if (num_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    tally_and_finish;
  end
  initial begin
    rnd = $urandom(63);
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    foreach (rnd[i]) if (i < 7) chk(8'hC8 + 8'(i), 8'h00, "reset value");
    chk(`ADDR_CLOCK_CTRL, 8'h00, "clock ctrl reset");
    r = 16'($urandom);
    wr_rd(`ADDR_RELOAD_LOW, r[7:0], v);
    `CHK("reload low", r[7:0], v)
    wr_rd(`ADDR_RELOAD_HIGH, r[15:8], v);
    `CHK("reload high", r[15:8], v)
    wr_rd(`ADDR_CONTROL, 8'h01, v);
    `CHK("control", 8'h01, v)
    wr_rd(`ADDR_CLOCK_CTRL, 8'h30, v);
    `CHK("clock selects", 2'b11, v[5:4])
    wr(`ADDR_CLOCK_CTRL, 8'h00);
    wr(8'hC9, 8'h5A);
    chk(8'hC9, 8'h00, "unmapped");
    // full 16-bit wrap reloads the pair and raises the high flag
    timer_irq_enable <= 1'b1;
    wr(`ADDR_COUNT_LOW, 8'hFE);
    wr(`ADDR_COUNT_HIGH, 8'hFF);
    wr(`ADDR_CONTROL, 8'h25);
    burst(8'h10, 2);
    m = adv(16'hFFFE, r, 16'hFFFF, 4);
    chk(`ADDR_COUNT_LOW, m[7:0], "count low");
    chk(`ADDR_COUNT_HIGH, m[15:8], "count high");
    rd(`ADDR_CONTROL, v);
    `CHK("high flag", 8'hA5, v & 8'hBF)
    chk(`ADDR_CONTROL, v, "flag kept");
    `CHK("irq on high flag", 1'b1, timer_irq)
    timer_irq_enable <= 1'b0;
    #1 `CHK("irq gated", 1'b0, timer_irq)
    timer_irq_enable <= 1'b1;
    wr(`ADDR_CONTROL, 8'h05);
    #1 `CHK("flags cleared", 1'b0, timer_irq)
    // low byte wrap alone: low flag only, irq needs its own enable
    wr(`ADDR_COUNT_LOW, 8'hFE);
    wr(`ADDR_COUNT_HIGH, 8'h12);
    burst(8'h10, 2);
    chk(`ADDR_COUNT_HIGH, 8'h13, "carry");
    chk(`ADDR_CONTROL, 8'h45, "low flag");
    `CHK("low flag no irq", 1'b0, timer_irq)
    wr(`ADDR_CONTROL, 8'h65);
    #1 `CHK("low flag irq", 1'b1, timer_irq)
    // split: low byte ignores run control, each byte its own reload
    rnd = 16'($urandom);
    wr(`ADDR_CONTROL, 8'h09);
    wr(`ADDR_RELOAD_LOW, rnd[7:0]);
    wr(`ADDR_RELOAD_HIGH, rnd[15:8]);
    wr(`ADDR_COUNT_LOW, 8'hFD);
    wr(`ADDR_COUNT_HIGH, 8'hF0);
    burst(8'h30, 3);
    m = adv(16'h00FD, {8'h00, rnd[7:0]}, 16'h00FF, 5);
    r = m[15:0];
    chk(`ADDR_COUNT_LOW, r[7:0], "split low");
    chk(`ADDR_COUNT_HIGH, 8'hF0, "split high held");
    chk(`ADDR_CONTROL, 8'h49, "split low flag");
    wr(`ADDR_CONTROL, 8'h0D);
    wr(`ADDR_COUNT_HIGH, 8'hFE);
    burst(8'h20, 1);
    m = adv(16'h00FE, {8'h00, rnd[15:8]}, 16'h00FF, 3);
    chk(`ADDR_COUNT_HIGH, m[7:0], "split high");
    chk(`ADDR_COUNT_LOW, r[7:0], "low idle on ext");
    chk(`ADDR_CONTROL, 8'h8D, "split high flag");
    `CHK("split irq", 1'b1, timer_irq)
    // divided sources: 120 run edges give 10 ticks, 16 rises give 2
    wr(`ADDR_CONTROL, 8'h00);
    wr(`ADDR_COUNT_LOW, 8'h00);
    wr(`ADDR_COUNT_HIGH, 8'h00);
    wr(`ADDR_CONTROL, 8'h04);
    repeat (118) @(posedge clk_sys);
    wr(`ADDR_CONTROL, 8'h01);
    chk(`ADDR_COUNT_LOW, 8'h0A, "div 12");
    wr(`ADDR_COUNT_LOW, 8'h00);
    wr(`ADDR_CONTROL, 8'h05);
    repeat (32) begin
      ext_osc <= ~ext_osc;
      repeat (3) @(posedge clk_sys);
    end
    repeat (8) @(posedge clk_sys);
    wr(`ADDR_CONTROL, 8'h01);
    chk(`ADDR_COUNT_LOW, 8'h02, "ext div 8");
    // capture of a stopped count, once per event, from each source
    rnd = 16'($urandom);
    wr(`ADDR_COUNT_LOW, rnd[7:0]);
    wr(`ADDR_COUNT_HIGH, rnd[15:8]);
    wr(`ADDR_CONTROL, 8'h11);
    sof_event <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk(`ADDR_RELOAD_LOW, rnd[7:0], "sof capture low");
    chk(`ADDR_RELOAD_HIGH, rnd[15:8], "sof capture high");
    `CHK("capture irq", 1'b1, timer_irq)
    wr(`ADDR_COUNT_LOW, 8'h3C);
    repeat (8) @(posedge clk_sys);
    chk(`ADDR_RELOAD_LOW, rnd[7:0], "one capture");
    wr(`ADDR_CONTROL, 8'h13);
    #1 `CHK("pending cleared", 1'b0, timer_irq)
    sof_event <= 1'b0;
    low_freq_osc <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk(`ADDR_RELOAD_LOW, 8'h3C, "oscillator fall");
    low_freq_osc <= 1'b1;
    wr(`ADDR_COUNT_LOW, 8'h77);
    repeat (8) @(posedge clk_sys);
    chk(`ADDR_RELOAD_LOW, 8'h3C, "oscillator rise");
    wr(`ADDR_CONTROL, 8'h1B);
    low_freq_osc <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk(`ADDR_RELOAD_LOW, 8'h77, "split capture low");
    chk(`ADDR_RELOAD_HIGH, rnd[15:8], "split capture high");
    tally_and_finish;
  end
endmodule
